/* pwp_port.sv */
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pwp_port import pwp_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] data_in_n,
	output logic [31:0] data_out_n,
	output logic [31:0] data_oe,
	output logic dir_n,
	output logic dcmd_n,
	output logic step_n,
	output logic end_n,
	output logic dev_reset_n,
	output logic strobe_n,
	input wire logic strobe_ack_n
);

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_got;
		logic w_got;
		logic [5:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic dir;
		logic dcmd;
		logic [1:0] width;
		logic last;
		logic [31:0] out_buf;
		logic [1:0] idx;
		logic full;
		pwp_seq_t seq;
		logic step_seen;
		logic step_fire;
		logic strobe;
		logic end_flag;
		logic rst_fire;
		logic [31:0] pin_data_n;
		logic [31:0] pin_oe;
		logic pin_dir_n;
		logic pin_dcmd_n;
		logic pin_end_n;
		logic pin_strobe_n;
		logic pin_step_n;
		logic pin_reset_n;
	} pwp_state_t;

	pwp_state_t s_reg;
	pwp_state_t s_next;
	logic step_pulse;
	logic rst_pulse;
	logic ack;

	// Lanes in use for a width code: 0 = 8 bits up to 3 = 32 bits.
	function automatic logic [31:0] lane_mask(input logic [1:0] w);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			if (2'(i) <= w) begin
				m[i*8 +: 8] = 8'hFF;
			end
		end
		return m;
	endfunction : lane_mask

	pwp_oneshot #(
		.LENGTH(PULSE_CNT_W'(STEP_CYCLES))
	) u_step (
		.aclk(aclk),
		.aresetn(aresetn),
		.fire(s_reg.step_fire),
		.pulse(step_pulse)
	);

	pwp_oneshot #(
		.LENGTH(PULSE_CNT_W'(RESET_CYCLES))
	) u_reset (
		.aclk(aclk),
		.aresetn(aresetn),
		.fire(s_reg.rst_fire),
		.pulse(rst_pulse)
	);

	assign ack = ~strobe_ack_n;

	always_comb begin
		s_next = s_reg;
		s_next.step_fire = 1'b0;
		s_next.rst_fire = 1'b0;

		// Write address and data are taken in either order.
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_got = 1'b1;
			s_next.awready = 1'b0;
			s_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_got = 1'b1;
			s_next.wready = 1'b0;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
			s_next.awready = 1'b1;
			s_next.wready = 1'b1;
		end

		// Handshake sequence shared by automatic transfers and the step and strobe jump commands.
		unique case (s_reg.seq)
			SEQ_IDLE: begin
			end
			SEQ_STEP: begin
				if (step_pulse) begin
					s_next.step_seen = 1'b1;
				end else if (s_reg.step_seen) begin
					s_next.seq = SEQ_STROBE;
					s_next.strobe = 1'b1;
				end
			end
			SEQ_STROBE: begin
				if (ack) begin
					s_next.strobe = 1'b0;
					s_next.seq = SEQ_DONE;
				end
			end
			SEQ_DONE: begin
				if (s_reg.last) begin
					s_next.end_flag = 1'b1;
				end
				s_next.full = 1'b0;
				s_next.idx = s_reg.width;
				s_next.seq = SEQ_IDLE;
			end
		endcase

		if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			unique case (s_reg.awaddr)
				ADDR_CTRL: begin
					if (s_reg.wstrb[0]) begin
						s_next.last = s_reg.wdata[CTRL_LAST];
						if (s_reg.wdata[CTRL_RESET]) begin
							s_next.dir = 1'b0;
							s_next.dcmd = 1'b0;
							s_next.end_flag = 1'b0;
							s_next.strobe = 1'b0;
							s_next.seq = SEQ_IDLE;
							s_next.full = 1'b0;
							s_next.idx = s_reg.width;
							s_next.rst_fire = 1'b1;
						end else if (s_reg.seq == SEQ_IDLE) begin
							if (s_reg.wdata[CTRL_AUTO] || s_reg.wdata[CTRL_JUMP_STEP]) begin
								s_next.step_fire = 1'b1;
								s_next.step_seen = 1'b0;
								s_next.end_flag = 1'b0;
								s_next.seq = SEQ_STEP;
							end else if (s_reg.wdata[CTRL_JUMP_STROBE]) begin
								s_next.strobe = 1'b1;
								s_next.seq = SEQ_STROBE;
							end
							if (s_reg.wdata[CTRL_JUMP_END]) begin
								s_next.end_flag = 1'b1;
							end
						end
					end
				end
				ADDR_MODE: begin
					if (s_reg.wstrb[0]) begin
						s_next.dir = s_reg.wdata[MODE_DIR];
						s_next.dcmd = s_reg.wdata[MODE_DCMD];
						s_next.width = s_reg.wdata[MODE_WIDTH_LO +: 2];
						s_next.idx = s_reg.wdata[MODE_WIDTH_LO +: 2];
						s_next.full = 1'b0;
					end
				end
				ADDR_OUT_BYTE: begin
					// Bytes land from the top lane of the word downward.
					if (s_reg.wstrb[0] && !s_reg.full) begin
						s_next.out_buf[s_reg.idx*8 +: 8] = s_reg.wdata[7:0];
						if (s_reg.idx == 2'h0) begin
							s_next.full = 1'b1;
							s_next.idx = s_reg.width;
						end else begin
							s_next.idx = s_reg.idx - 2'h1;
						end
					end
				end
				ADDR_OUT_WORD: begin
					for (int b = 0; b < 4; b++) begin
						if (s_reg.wstrb[b]) begin
							s_next.out_buf[b*8 +: 8] = s_reg.wdata[b*8 +: 8];
						end
					end
					s_next.full = 1'b1;
					s_next.idx = s_reg.width;
				end
				default: begin
					s_next.bresp = RESP_SLVERR;
				end
			endcase
		end

		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
			s_next.arready = 1'b1;
		end
		if (s_axi_arvalid && s_reg.arready) begin
			s_next.arready = 1'b0;
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			s_next.rdata = '0;
			unique case (s_axi_araddr)
				ADDR_CTRL: begin
					s_next.rdata[CTRL_LAST] = s_reg.last;
				end
				ADDR_MODE: begin
					s_next.rdata[MODE_DIR] = s_reg.dir;
					s_next.rdata[MODE_DCMD] = s_reg.dcmd;
					s_next.rdata[MODE_WIDTH_LO +: 2] = s_reg.width;
				end
				ADDR_OUT_BYTE, ADDR_OUT_WORD: begin
					s_next.rdata = s_reg.out_buf & lane_mask(s_reg.width);
				end
				ADDR_IN_BYTE: begin
					// Taken live from the receivers, highest byte first.
					s_next.rdata[7:0] = ~data_in_n[s_reg.idx*8 +: 8];
					s_next.idx = (s_reg.idx == 2'h0) ? s_reg.width : s_reg.idx - 2'h1;
				end
				ADDR_STATUS: begin
					s_next.rdata[1:0] = s_reg.seq;
					s_next.rdata[2] = s_reg.full;
					s_next.rdata[3] = step_pulse;
					s_next.rdata[4] = s_reg.strobe;
					s_next.rdata[5] = ack;
					s_next.rdata[6] = s_reg.end_flag;
					s_next.rdata[9:8] = s_reg.idx;
				end
				default: begin
					s_next.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Pin stage: every peripheral output is registered; all but data_oe are negative-true.
		s_next.pin_data_n = ~(s_reg.out_buf & lane_mask(s_reg.width));
		s_next.pin_oe = s_reg.dir ? '0 : lane_mask(s_reg.width);
		s_next.pin_dir_n = ~s_reg.dir;
		s_next.pin_dcmd_n = ~s_reg.dcmd;
		s_next.pin_end_n = ~s_reg.end_flag;
		s_next.pin_strobe_n = ~s_reg.strobe;
		s_next.pin_step_n = ~step_pulse;
		s_next.pin_reset_n = ~(rst_pulse || s_reg.rst_fire);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.awready <= 1'b1;
			s_reg.wready <= 1'b1;
			s_reg.arready <= 1'b1;
			s_reg.width <= WIDTH_RESET;
			s_reg.idx <= WIDTH_RESET;
			s_reg.seq <= SEQ_IDLE;
			s_reg.pin_data_n <= '1;
			s_reg.pin_dir_n <= 1'b1;
			s_reg.pin_dcmd_n <= 1'b1;
			s_reg.pin_end_n <= 1'b1;
			s_reg.pin_strobe_n <= 1'b1;
			s_reg.pin_step_n <= 1'b1;
			s_reg.pin_reset_n <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign s_axi_rvalid = s_reg.rvalid;
	assign data_out_n = s_reg.pin_data_n;
	assign data_oe = s_reg.pin_oe;
	assign dir_n = s_reg.pin_dir_n;
	assign dcmd_n = s_reg.pin_dcmd_n;
	assign step_n = s_reg.pin_step_n;
	assign end_n = s_reg.pin_end_n;
	assign dev_reset_n = s_reg.pin_reset_n;
	assign strobe_n = s_reg.pin_strobe_n;

endmodule : pwp_port

`default_nettype wire

/* pwp_pkg.sv */
package pwp_pkg;

	localparam int CLK_FREQ_MHZ = 40;
	localparam int STEP_PULSE_NS = 500;
	localparam int STEP_CYCLES = (STEP_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int RESET_PULSE_NS = 500;
	localparam int RESET_CYCLES = (RESET_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int PULSE_CNT_W = 6;

	localparam logic [5:0] ADDR_CTRL = 6'h00;
	localparam logic [5:0] ADDR_MODE = 6'h04;
	localparam logic [5:0] ADDR_OUT_BYTE = 6'h08;
	localparam logic [5:0] ADDR_IN_BYTE = 6'h0C;
	localparam logic [5:0] ADDR_STATUS = 6'h10;
	localparam logic [5:0] ADDR_OUT_WORD = 6'h14;

	localparam int CTRL_RESET = 0;
	localparam int CTRL_AUTO = 1;
	localparam int CTRL_LAST = 2;
	localparam int CTRL_JUMP_STEP = 3;
	localparam int CTRL_JUMP_END = 4;
	localparam int CTRL_JUMP_STROBE = 5;

	localparam int MODE_DIR = 0;
	localparam int MODE_DCMD = 1;
	localparam int MODE_WIDTH_LO = 2;

	localparam logic [1:0] WIDTH_RESET = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_STEP = 2'b01,
		SEQ_STROBE = 2'b11,
		SEQ_DONE = 2'b10
	} pwp_seq_t;

endpackage : pwp_pkg

/* pwp_oneshot.sv */
`timescale 1ns/1ps
`default_nettype none

// Retriggerable-free single shot: a fire while running is ignored.
module pwp_oneshot import pwp_pkg::*; #(
	parameter logic [PULSE_CNT_W-1:0] LENGTH = PULSE_CNT_W'(STEP_CYCLES)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic fire,
	output logic pulse
);

	typedef struct packed {
		logic active;
		logic [PULSE_CNT_W-1:0] cnt;
	} pwp_shot_t;

	pwp_shot_t s_reg;
	pwp_shot_t s_next;

	always_comb begin
		s_next = s_reg;
		if (s_reg.active) begin
			if (s_reg.cnt == PULSE_CNT_W'(1)) begin
				s_next.active = 1'b0;
			end
			s_next.cnt = s_reg.cnt - PULSE_CNT_W'(1);
		end else if (fire) begin
			s_next.active = 1'b1;
			s_next.cnt = LENGTH;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pulse = s_reg.active;

endmodule : pwp_oneshot

`default_nettype wire

/* pwp_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pwp_port_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] data_out_n,
	input wire logic [31:0] data_oe,
	input wire logic dir_n,
	input wire logic step_n,
	input wire logic dev_reset_n,
	input wire logic strobe_n,
	input wire logic strobe_ack_n
);
	logic [5:0] step_cnt;
	logic [5:0] rst_cnt;
	always_ff @(posedge aclk) begin
		step_cnt <= step_n ? 6'h00 : step_cnt + 6'h01;
		rst_cnt <= (dev_reset_n || !aresetn) ? 6'h00 : rst_cnt + 6'h01;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_oe_dir; |data_oe |-> dir_n; endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("oe in input");
	property p_oe_lanes; data_oe inside {32'h0, 32'hFF, 32'hFFFF, 32'hFFFFFF, 32'hFFFFFFFF};
	endproperty
	a_oe_lanes: assert property (p_oe_lanes) else $error("oe lanes");
	property p_idle_hi; dir_n |-> &(data_out_n | data_oe); endproperty
	a_idle_hi: assert property (p_idle_hi) else $error("idle lane low");
	property p_step_w; $rose(step_n) |-> step_cnt == 6'h14; endproperty
	a_step_w: assert property (p_step_w) else $error("step width");
	property p_step_str; !step_n |-> strobe_n; endproperty
	a_step_str: assert property (p_step_str) else $error("strobe in step");
	property p_str_hold; !strobe_n && strobe_ack_n |=> !strobe_n; endproperty
	a_str_hold: assert property (p_str_hold) else $error("strobe dropped");
	property p_str_rel; !strobe_n && !strobe_ack_n |-> ##[1:3] strobe_n; endproperty
	a_str_rel: assert property (p_str_rel) else $error("strobe held");
	property p_bus_rst; disable iff (1'b0) !aresetn |=> !dev_reset_n && data_oe == 32'h0;
	endproperty
	a_bus_rst: assert property (p_bus_rst) else $error("bus reset");
	property p_rst_w; $rose(dev_reset_n) |-> rst_cnt inside {6'h01, 6'h15}; endproperty
	a_rst_w: assert property (p_rst_w) else $error("reset width");
endmodule : pwp_port_monitor
bind pwp_port pwp_port_monitor i_pwp_port_monitor (.aclk(aclk), .aresetn(aresetn),
	.data_out_n(data_out_n), .data_oe(data_oe), .dir_n(dir_n), .step_n(step_n),
	.dev_reset_n(dev_reset_n), .strobe_n(strobe_n), .strobe_ack_n(strobe_ack_n));
`default_nettype wire

/* pwp_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module pwp_partner (
	input wire logic aclk,
	input wire logic strobe_n,
	input wire logic dir_n,
	input wire logic [31:0] wire_n,
	input wire logic [31:0] word,
	input wire logic [3:0] lag,
	output logic ack_n,
	output logic [31:0] pdata_n,
	output logic [31:0] got
);
	logic [3:0] n;
	assign pdata_n = dir_n ? 32'hFFFFFFFF : ~word;
	initial ack_n = 1'b1;
	always @(posedge aclk) begin
		if (strobe_n) begin
			ack_n <= 1'b1;
			n <= 4'h0;
		end else begin
			if (n == 4'h0) got <= ~wire_n;
			if (n >= lag) ack_n <= 1'b0;
			n <= n + 4'h1;
		end
	end
endmodule : pwp_partner
`default_nettype wire

/* tb_pwp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pwp_port import pwp_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
	logic dir_n, dcmd_n, step_n, end_n, drst_n, strobe_n, ack_n;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata, word, got, e, din_n, pd_n, data_out_n, data_oe;
	logic [3:0] lag;
	logic [1:0] bresp, rresp;
	logic [2:0] pins;
	int err_total, cmp_count, w, i;
	always #12.5 aclk = ~aclk;
	assign din_n = data_oe & data_out_n | ~data_oe & pd_n;
	assign pins = {strobe_n, end_n, step_n};
	pwp_port i_pwp_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .data_in_n(din_n),
		.data_out_n(data_out_n), .data_oe(data_oe), .dir_n(dir_n), .dcmd_n(dcmd_n),
		.step_n(step_n), .end_n(end_n), .dev_reset_n(drst_n), .strobe_n(strobe_n),
		.strobe_ack_n(ack_n));
	pwp_partner i_pwp_partner (.aclk(aclk), .strobe_n(strobe_n), .dir_n(dir_n),
		.wire_n(din_n), .word(word), .lag(lag), .ack_n(ack_n), .pdata_n(pd_n), .got(got));
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic hang;
		err_total++;
		$display("[FAIL] %0t timeout", $time);
		tally_and_finish();
	endtask : hang
	task automatic ck(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask : ck
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) hang();
		ck(32'(bresp), 32'(r));
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [31:0] x, input logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) hang();
		ck(rdata, x);
		ck(32'(rresp), 32'(r));
	endtask : rd
	task automatic wl(input int k);
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge aclk);
			#1;
			if (pins[k] === 1'b0) return;
		end
		hang();
	endtask : wl
	task automatic pw;
		repeat (2) @(posedge aclk);
		#1;
	endtask : pw
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		awaddr = 6'h00;
		araddr = 6'h00;
		wdata = 32'h0;
		word = 32'h12345678;
		lag = 4'h0;
		err_total = 0;
		cmp_count = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ADDR_MODE, 32'hC, RESP_OKAY);
		wr(6'h18, 32'h0, RESP_SLVERR);
		rd(6'h3C, 32'h0, RESP_SLVERR);
		for (w = 0; w < 4; w++) begin
			wr(ADDR_MODE, 32'(w * 4 + w % 2 * 2), RESP_OKAY);
			lag <= 4'(w * 3);
			e = 32'h0;
			for (i = 0; i <= w; i++) begin
				e = e << 8 | 32'(i * 34 + 129);
				wr(ADDR_OUT_BYTE, e & 32'hFF, RESP_OKAY);
			end
			wr(ADDR_CTRL, 32'h6, RESP_OKAY);
			wl(2);
			wl(1);
			ck(got, e);
			ck(data_oe, 32'hFFFFFFFF >> (24 - 8 * w));
			ck(32'(dcmd_n), (w % 2 == 1) ? 32'h0 : 32'h1);
		end
		wr(ADDR_MODE, 32'hF, RESP_OKAY);
		pw();
		ck(32'(dir_n), 32'h0);
		ck(data_oe, 32'h0);
		wr(ADDR_CTRL, 32'h6, RESP_OKAY);
		wl(2);
		wl(1);
		for (i = 0; i < 4; i++) rd(ADDR_IN_BYTE, word >> (24 - 8 * i) & 32'hFF, RESP_OKAY);
		word <= 32'h9ABCDEF0;
		rd(ADDR_IN_BYTE, 32'h9A, RESP_OKAY);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		pw();
		ck(32'(drst_n), 32'h0);
		ck(32'({dir_n, dcmd_n}), 32'h3);
		wr(ADDR_OUT_WORD, 32'hC33C5AA5, RESP_OKAY);
		wr(ADDR_OUT_BYTE, 32'h11, RESP_OKAY);
		rd(ADDR_OUT_BYTE, 32'hC33C5AA5, RESP_OKAY);
		ck(data_out_n, 32'h3CC3A55A);
		rd(ADDR_STATUS, 32'h304, RESP_OKAY);
		for (i = 3; i < 6; i++) begin
			repeat (25) @(posedge aclk);
			wr(ADDR_CTRL, 32'(1 << i), RESP_OKAY);
			wl(i - 3);
			repeat (60) @(posedge aclk);
			wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		end
		repeat (25) @(posedge aclk);
		tally_and_finish();
	end
endmodule : tb_pwp_port
`default_nettype wire
